// file: core/spi_port_pkg.sv
// shared constants and types for the framed serial port
package spi_port_pkg;

	// ----------------------------------------------------------------
	// bus geometry and register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_STATUS  = 8'h00;
	localparam logic [7:0]  OFF_CTRL1   = 8'h04;
	localparam logic [7:0]  OFF_CTRL2   = 8'h08;
	localparam logic [7:0]  OFF_DATA    = 8'h0C;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// register select codes
	localparam logic [2:0] SEL_STAT = 3'h0;
	localparam logic [2:0] SEL_C1   = 3'h1;
	localparam logic [2:0] SEL_C2   = 3'h2;
	localparam logic [2:0] SEL_DATA = 3'h3;
	localparam logic [2:0] SEL_NONE = 3'h4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned STAT_EN    = 15;
	localparam int unsigned STAT_IDLE  = 13;
	localparam int unsigned STAT_OVF   = 6;
	localparam int unsigned C1_CLKDIS  = 12;
	localparam int unsigned C1_OUTDIS  = 11;
	localparam int unsigned C1_WIDE    = 10;
	localparam int unsigned C1_SMP     = 9;
	localparam int unsigned C1_CKE     = 8;
	localparam int unsigned C1_SELECT_ENABLE    = 7;
	localparam int unsigned C1_CKP     = 6;
	localparam int unsigned C1_MST     = 5;
	localparam int unsigned C2_FEN     = 15;
	localparam int unsigned C2_FSD     = 14;
	localparam int unsigned C2_FPOL    = 13;
	localparam int unsigned C2_FDLY    = 1;

	// ----------------------------------------------------------------
	// writable masks, reset values, transfer lengths
	// ----------------------------------------------------------------
	localparam logic [15:0] C1_WMASK  = 16'h1FFF;
	localparam logic [15:0] C2_WMASK  = 16'hE002;
	localparam logic [15:0] REG_RST   = 16'h0000;
	localparam logic [4:0]  BITS_BYTE = 5'h08;
	localparam logic [4:0]  BITS_WORD = 5'h10;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE  = 2'b01,
		ST_RUN  = 2'b10
	} xfer_state_e;

endpackage : spi_port_pkg

// file: core/spi_port.sv
// serial peripheral port, master or slave, with framed mode and axi-lite regs
//
// Contract
// - 16-bit shift register; buffer holds separate transmit and receive words.
// - master drives the shift clock pin; slave takes it as input.
// - enable bit hands the four pins to the port; clear disables it.
// - idle-stop set freezes the port while the device idles.
// - word arriving with receive buffer still full is dropped, overflow set.
// - transmit-full sets on buffer write, clears on load into shifter.
// - receive-full sets on shifter-to-buffer move, clears on buffer read.
// - master clock disable stops clock, releases pin; out disable releases data.
// - width bit picks 16-bit or 8-bit transfers.
// - master samples at end of output time if set, else middle.
// - edge bit: data changes active-to-idle if set, else idle-to-active.
// - polarity bit set makes clock idle high, else idle low.
// - slave with select enable uses active-low select pin.
// - master-enable bit chooses master when set, slave when clear.
// - master clock divided by secondary 1..8 and primary 1,4,16,64.
// - framed mode: select pin carries frame sync; clock runs continuously.
// - sync direction: set means sync input, clear means port drives it.
// - sync polarity: set active-high, clear active-low.
// - sync edge: set coincides with first bit, clear one bit earlier.
`timescale 1ns/1ps
`default_nettype none

module spi_port (
	input  wire logic                        CLK,              // 100 MHz clock
	input  wire logic                        RST_N,            // sync reset
	input  wire logic                        IDLE_MODE,        // device idles
	input  wire logic                        AWVALID,          // aw valid
	output var  logic                        AWREADY,          // aw ready
	input  wire logic [spi_port_pkg::ADDR_W-1:0] AWADDR,       // aw address
	input  wire logic [2:0]                  AWPROT,           // unused
	input  wire logic                        WVALID,           // w valid
	output var  logic                        WREADY,           // w ready
	input  wire logic [31:0]                 WDATA,            // w data
	input  wire logic [3:0]                  WSTRB,            // byte lanes
	output var  logic                        BVALID,           // b valid
	input  wire logic                        BREADY,           // b ready
	output var  logic [1:0]                  BRESP,            // b response
	input  wire logic                        ARVALID,          // ar valid
	output var  logic                        ARREADY,          // ar ready
	input  wire logic [spi_port_pkg::ADDR_W-1:0] ARADDR,       // ar address
	input  wire logic [2:0]                  ARPROT,           // unused
	output var  logic                        RVALID,           // r valid
	input  wire logic                        RREADY,           // r ready
	output var  logic [31:0]                 RDATA,            // r data
	output var  logic [1:0]                  RRESP,            // r response
	input  wire logic                        SHIFT_CLOCK_IN,   // clock pin in
	output var  logic                        SHIFT_CLOCK_OUT,  // clock pin out
	output var  logic                        SHIFT_CLOCK_OE_N, // clock drive
	input  wire logic                        SERIAL_IN,        // data in pin
	output var  logic                        SERIAL_OUT,       // data out pin
	output var  logic                        SERIAL_OUT_OE_N,  // data drive
	input  wire logic                        SELECT_N_IN,      // select in
	output var  logic                        SELECT_N_OUT,     // sync out
	output var  logic                        SELECT_N_OE_N     // select drive
);
	import spi_port_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                en;
		logic                idle_stop;
		logic                ovf;
		logic                txf;
		logic                rxf;
		logic [15:0]         con1;
		logic [15:0]         con2;
		logic [15:0]         tx_buf;
		logic [15:0]         rx_buf;
		logic [15:0]         sr;
		logic                samp;
		logic [4:0]          cnt;
		xfer_state_e         st;
		logic [9:0]          div_cnt;
		logic                act;
		logic                sync_on;
		logic                sck_m;
		logic                sck_s;
		logic                sck_p;
		logic                sdi_m;
		logic                sdi_s;
		logic                ss_m;
		logic                ss_s;
		logic                sck_o;
		logic                sck_oe_n;
		logic                sdo_o;
		logic                sdo_oe_n;
		logic                ss_o;
		logic                ss_oe_n;
		logic                aw_got;
		logic [ADDR_W-1:0]   aw_addr;
		logic                w_got;
		logic [15:0]         wdata;
		logic [1:0]          wstrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [15:0]         rdata;
		logic [1:0]          rresp;
	} port_state_s;

	port_state_s s;
	port_state_s n;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		unique case ({a[ADDR_W-1:2], 2'b00})
			OFF_STATUS: reg_sel = SEL_STAT;
			OFF_CTRL1:  reg_sel = SEL_C1;
			OFF_CTRL2:  reg_sel = SEL_C2;
			OFF_DATA:   reg_sel = SEL_DATA;
			default:    reg_sel = SEL_NONE;
		endcase
	endfunction : reg_sel

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [15:0] d, input logic [1:0] b);
		merge16 = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// divide ratio = primary x secondary; 1:1 on both is left to software
	function automatic logic [9:0] clk_div(input logic [15:0] c1);
		logic [6:0] p;
		logic [3:0] q;
		unique case (c1[1:0])
			2'b11:   p = 7'h01;
			2'b10:   p = 7'h04;
			2'b01:   p = 7'h10;
			default: p = 7'h40;
		endcase
		q = 4'h8 - {1'b0, c1[4:2]};
		clk_div = {3'h0, p} * {6'h0, q};
	endfunction : clk_div

	// ----------------------------------------------------------------
	// decode of configuration and edges
	// ----------------------------------------------------------------
	logic        master;
	logic        wide;
	logic        cke;
	logic        clock_polarity;
	logic        smp_eff;
	logic        framed;
	logic        fsd;
	logic        fpol;
	logic        fdly;
	logic        run_ok;
	logic        ss_act;
	logic        sync_in_act;
	logic [4:0]  nb;
	logic [9:0]  div;
	logic [9:0]  hlen;
	logic        gen_run;
	logic        g_edge;
	logic        lead;
	logic        trail;
	logic        mid_e;
	logic        out_e;
	logic [15:0] stat_rd;
	logic [15:0] rd_word;
	logic [2:0]  rsel;

	assign master  = s.con1[C1_MST];
	assign wide    = s.con1[C1_WIDE];
	assign nb      = wide ? BITS_WORD : BITS_BYTE;
	assign cke     = s.con1[C1_CKE];
	assign clock_polarity     = s.con1[C1_CKP];
	// sample phase only acts for a master; a slave always samples mid-bit
	assign smp_eff = s.con1[C1_SMP] & master;
	assign framed  = s.con2[C2_FEN];
	assign fsd     = s.con2[C2_FSD];
	assign fpol    = s.con2[C2_FPOL];
	assign fdly    = s.con2[C2_FDLY];
	assign run_ok  = s.en && !(s.idle_stop && IDLE_MODE);
	// select pin is ignored in framed mode, so a clash with it is harmless
	assign ss_act  = framed || !s.con1[C1_SELECT_ENABLE] || !s.ss_s;
	assign sync_in_act = fpol ? s.ss_s : !s.ss_s;

	// master clock generator: lead half first, odd ratios lengthen the tail
	assign div     = clk_div(s.con1);
	assign hlen    = s.act ? div - (div >> 1) : div >> 1;
	assign gen_run = master && !s.con1[C1_CLKDIS]
		&& (s.st != ST_IDLE || s.act || framed);
	assign g_edge  = gen_run && s.div_cnt == hlen - 10'h001;

	// slave edges come from the synchronised pin, seen after two flops
	assign lead  = master ? g_edge && !s.act
		: (s.sck_s ^ clock_polarity) && !(s.sck_p ^ clock_polarity);
	assign trail = master ? g_edge && s.act
		: !(s.sck_s ^ clock_polarity) && (s.sck_p ^ clock_polarity);
	assign mid_e = cke ? lead : trail;
	assign out_e = cke ? trail : lead;

	assign stat_rd = {s.en, 1'b0, s.idle_stop, 6'h00, s.ovf, 4'h0,
		s.txf, s.rxf};
	assign rsel = reg_sel(ARADDR);
	always_comb begin
		unique case (rsel)
			SEL_STAT: rd_word = stat_rd;
			SEL_C1:   rd_word = s.con1;
			SEL_C2:   rd_word = s.con2;
			SEL_DATA: rd_word = s.rx_buf;
			default:  rd_word = REG_RST;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        do_wr;
		logic [2:0]  wsel;
		logic [15:0] wv;
		logic        ld;
		logic        fin;
		logic        bin;
		logic [15:0] shv;
		do_wr = 1'b0;
		wsel  = SEL_NONE;
		wv    = REG_RST;
		ld    = 1'b0;
		fin   = 1'b0;
		bin   = s.samp;
		shv   = {s.sr[14:0], s.samp};
		n     = s;

		n.sck_m = SHIFT_CLOCK_IN;
		n.sck_s = s.sck_m;
		n.sck_p = s.sck_s;
		n.sdi_m = SERIAL_IN;
		n.sdi_s = s.sdi_m;
		n.ss_m  = SELECT_N_IN;
		n.ss_s  = s.ss_m;

		// read channel; a data read frees the receive buffer
		if (ARVALID && s.arready) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_word;
			n.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (rsel == SEL_DATA)
				n.rxf = 1'b0;
		end else if (RREADY && s.rvalid) begin
			n.rvalid = 1'b0;
		end

		// write channel: address and data taken in either order
		if (BREADY && s.bvalid)
			n.bvalid = 1'b0;
		if (AWVALID && s.awready) begin
			n.aw_got  = 1'b1;
			n.aw_addr = AWADDR;
		end
		if (WVALID && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = WDATA[15:0];
			n.wstrb = WSTRB[1:0];
		end
		do_wr = n.aw_got && n.w_got && !s.bvalid;
		wsel  = reg_sel(n.aw_addr);
		if (do_wr) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			unique case (wsel)
				SEL_STAT: begin
					wv = merge16(stat_rd, n.wdata, n.wstrb);
					n.en        = wv[STAT_EN];
					n.idle_stop = wv[STAT_IDLE];
					if (n.wstrb[0] && !wv[STAT_OVF])
						n.ovf = 1'b0;
				end
				SEL_C1: n.con1 = merge16(s.con1, n.wdata, n.wstrb)
					& C1_WMASK;
				// lowest bit of the second control word is held at zero
				SEL_C2: n.con2 = merge16(s.con2, n.wdata, n.wstrb)
					& C2_WMASK;
				default: wv = REG_RST;
			endcase
		end

		// transfer engine
		if (!s.en) begin
			n.st      = ST_IDLE;
			n.cnt     = 5'h00;
			n.act     = 1'b0;
			n.div_cnt = 10'h000;
			n.sync_on = 1'b0;
		end else if (run_ok) begin
			if (!gen_run)
				n.div_cnt = 10'h000;
			else if (g_edge) begin
				n.div_cnt = 10'h000;
				n.act     = !s.act;
			end else
				n.div_cnt = s.div_cnt + 10'h001;
			if (lead)
				n.sync_on = 1'b0;
			if (!master && !ss_act) begin
				n.st  = ST_IDLE;
				n.cnt = 5'h00;
			end else begin
				unique case (s.st)
					ST_IDLE: begin
						if (framed) begin
							// a frame opens at a bit boundary
							if (lead && (fsd ? sync_in_act : s.txf)) begin
								n.sync_on = !fsd;
								if (fdly)
									ld = 1'b1;
								else
									n.st = ST_PRE;
							end
						end else if (!master || (s.txf && !s.act))
							ld = 1'b1;
					end
					ST_PRE: begin
						if (lead)
							ld = 1'b1;
					end
					ST_RUN: begin
						if (mid_e) begin
							n.cnt = s.cnt + 5'h01;
							if (!smp_eff)
								n.samp = s.sdi_s;
							if (s.cnt == nb - 5'h01 && !(smp_eff && cke)) begin
								fin = 1'b1;
								bin = s.sdi_s;
							end
						end else if (out_e && s.cnt != 5'h00) begin
							bin = smp_eff ? s.sdi_s : s.samp;
							fin = (s.cnt == nb);
						end
						shv = {s.sr[14:0], bin};
						if (fin || (out_e && s.cnt != 5'h00))
							n.sr = shv;
						if (fin) begin
							n.st  = ST_IDLE;
							n.cnt = 5'h00;
							if (n.rxf)
								n.ovf = 1'b1;
							else begin
								n.rx_buf = wide ? shv : {8'h00, shv[7:0]};
								n.rxf    = 1'b1;
							end
						end
					end
					default: n.st = ST_IDLE;
				endcase
			end
			if (ld) begin
				if (s.txf)
					n.sr = s.tx_buf;
				n.txf  = 1'b0;
				n.cnt  = 5'h00;
				n.samp = 1'b0;
				n.st   = ST_RUN;
			end
		end

		// a buffer write after the engine so a same-cycle load loses
		if (do_wr && wsel == SEL_DATA) begin
			n.tx_buf = merge16(s.tx_buf, n.wdata, n.wstrb);
			n.txf    = 1'b1;
		end

		// pins, bus handshakes
		n.sck_o    = clock_polarity ^ n.act;
		n.sck_oe_n = !(s.en && master && !s.con1[C1_CLKDIS]);
		// the line moves only at a load or an output edge, never at the
		// completing edge, so the last bit keeps its whole slot
		if (ld || (n.st == ST_RUN && out_e))
			n.sdo_o = wide ? n.sr[15] : n.sr[7];
		n.sdo_oe_n = !(s.en && !s.con1[C1_OUTDIS]);
		n.ss_o     = fpol ? n.sync_on : !n.sync_on;
		n.ss_oe_n  = !(s.en && framed && !fsd);
		n.awready  = !n.aw_got && !n.bvalid;
		n.wready   = !n.w_got && !n.bvalid;
		n.arready  = !n.rvalid;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			s          <= '0;
			s.sck_oe_n <= 1'b1;
			s.sdo_oe_n <= 1'b1;
			s.ss_oe_n  <= 1'b1;
			s.ss_o     <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign AWREADY          = s.awready;
	assign WREADY           = s.wready;
	assign BVALID           = s.bvalid;
	assign BRESP            = s.bresp;
	assign ARREADY          = s.arready;
	assign RVALID           = s.rvalid;
	assign RDATA            = {16'h0000, s.rdata};
	assign RRESP            = s.rresp;
	assign SHIFT_CLOCK_OUT  = s.sck_o;
	assign SHIFT_CLOCK_OE_N = s.sck_oe_n;
	assign SERIAL_OUT       = s.sdo_o;
	assign SERIAL_OUT_OE_N  = s.sdo_oe_n;
	assign SELECT_N_OUT     = s.ss_o;
	assign SELECT_N_OE_N    = s.ss_oe_n;

endmodule : spi_port

`default_nettype wire

// file: tb/spi_port_chk.sv
// bus-side checker for the serial port, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module spi_port_chk (
	input wire logic                              CLK,     // clock
	input wire logic                              RST_N,   // reset
	input wire logic                              AWVALID, // aw valid
	input wire logic                              AWREADY, // aw ready
	input wire logic [spi_port_pkg::ADDR_W-1:0]   AWADDR,  // aw address
	input wire logic                              WVALID,  // w valid
	input wire logic                              WREADY,  // w ready
	input wire logic                              BVALID,  // b valid
	input wire logic                              BREADY,  // b ready
	input wire logic [1:0]                        BRESP,   // b response
	input wire logic                              ARVALID, // ar valid
	input wire logic                              ARREADY, // ar ready
	input wire logic [spi_port_pkg::ADDR_W-1:0]   ARADDR,  // ar address
	input wire logic                              RVALID,  // r valid
	input wire logic                              RREADY,  // r ready
	input wire logic [31:0]                       RDATA,   // r data
	input wire logic [1:0]                        RRESP    // r response
);
	import spi_port_pkg::*;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	sequence s_wr_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence s_b_done;
		BVALID && BREADY;
	endsequence
	property p_b_lat;
		s_wr_taken |=> BVALID;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_refuse;
		BVALID |-> !AWREADY && !WREADY;
	endproperty
	a_b_refuse: assert property (p_b_refuse) else $error("write taken early");
	// a missing reopen would hang every later write
	property p_b_reopen;
		s_b_done |-> ##[1:2] (AWREADY && WREADY);
	endproperty
	a_b_reopen: assert property (p_b_reopen) else $error("write not reopened");
	property p_b_unmap;
		s_wr_taken and ((AWADDR >> 2) > (OFF_DATA >> 2)) |=> BRESP == RESP_SLVERR;
	endproperty
	a_b_unmap: assert property (p_b_unmap) else $error("unmapped write okay");

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	property p_r_lat;
		ARVALID && ARREADY |=> RVALID;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_refuse;
		RVALID |-> !ARREADY;
	endproperty
	a_r_refuse: assert property (p_r_refuse) else $error("read taken early");
	property p_r_unmap;
		ARVALID && ARREADY && ((ARADDR >> 2) > (OFF_DATA >> 2))
			|=> RRESP == RESP_SLVERR && RDATA == 32'h0000_0000;
	endproperty
	a_r_unmap: assert property (p_r_unmap) else $error("unmapped read okay");
	property p_r_upper;
		RVALID |-> RDATA[31:16] == 16'h0000;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper half set");
	property p_rst_quiet;
		$rose(RST_N) |-> !AWREADY && !WREADY && !ARREADY && !BVALID && !RVALID;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("bus live in reset");
endmodule : spi_port_chk

bind spi_port spi_port_chk u_chk (.CLK, .RST_N, .AWVALID, .AWREADY, .AWADDR,
	.WVALID, .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
	.RVALID, .RREADY, .RDATA, .RRESP);

`default_nettype wire

// file: tb/spi_peer.sv
// behavioural serial peripheral standing on the far side of the port
`timescale 1ns/1ps
`default_nettype none

module spi_peer (
	input  wire logic        clk,   // system clock
	input  wire logic        sck,   // shift clock from the port
	input  wire logic        mosi,  // data from the port
	output var  logic        miso,  // data to the port
	input  wire logic        load,  // take a new reply word
	input  wire logic [15:0] reply, // word sent back
	output var  logic [15:0] got    // bits taken in
);
	logic        sck_q;
	logic [15:0] sh;

	assign miso = sh[15];

	always @(posedge clk) begin
		sck_q <= sck;
		if (load)
			sh <= reply;
		// past the reply the line keeps changing, never a stale bit
		else if (!sck && sck_q)
			sh <= {sh[14:0], ~sh[15]};
		if (sck && !sck_q)
			got <= {got[14:0], mosi};
	end
endmodule : spi_peer

`default_nettype wire

// file: tb/spi_port_test.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module spi_port_test;
	import spi_port_pkg::*;

	logic              clk = 1'b0, rst_n = 1'b0, idle_mode = 1'b0;
	logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [31:0]       wdata = 32'h0000_0000, rdata;
	logic              bready = 1'b1, rready = 1'b1, load = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid, miso;
	logic [1:0]        bresp, rresp;
	logic              sck_o, sck_oe_n, so, so_oe_n, sel_o, sel_oe_n;
	logic [15:0]       rep = 16'h0000, got;
	logic              sck_q = 1'b0, sck_in = 1'b0, sel_in = 1'b1;
	int                bad_count = 0, samples_checked = 0;
	int                nedge = 0, first = 0, last = 0, cyc = 0;

	always #5 clk = ~clk;

	spi_port dut (.CLK(clk), .RST_N(rst_n), .IDLE_MODE(idle_mode),
		.AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
		.WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
		.BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
		.ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid),
		.RREADY(rready), .RDATA(rdata), .RRESP(rresp),
		.SHIFT_CLOCK_IN(sck_in), .SHIFT_CLOCK_OUT(sck_o),
		.SHIFT_CLOCK_OE_N(sck_oe_n),
		.SERIAL_IN(miso), .SERIAL_OUT(so), .SERIAL_OUT_OE_N(so_oe_n),
		.SELECT_N_IN(sel_in), .SELECT_N_OUT(sel_o), .SELECT_N_OE_N(sel_oe_n));

	spi_peer peer (.clk(clk), .sck(sck_o), .mosi(so), .miso(miso),
		.load(load), .reply(rep), .got(got));

	// counts rising clock edges and stamps the first and last of them
	always @(posedge clk) begin
		cyc++;
		if (sck_o && !sck_q) begin
			if (nedge == 0)
				first = cyc;
			last = cyc;
			nedge++;
		end
		sck_q = sck_o;
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	task automatic hang;
		bad_count++;
		$display("[FAIL] wait exp done got timeout");
		end_sim();
	endtask : hang

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		output logic [1:0] r);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b0;
		for (int n = 0; n < 100; n++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				return;
			end
			// one cycle of back-pressure so the hold checks see traffic
			if (bvalid)
				bready <= 1'b1;
		end
		hang();
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b0;
		for (int n = 0; n < 100; n++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata[15:0];
				r = rresp;
				return;
			end
			if (rvalid)
				rready <= 1'b1;
		end
		hang();
	endtask : rd

	task automatic w(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		wr(a, d, r);
		`CHK("write resp", RESP_OKAY, r)
	endtask : w

	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		logic [1:0]  r;
		rd(a, v, r);
		`CHK("read value", e, v)
	endtask : rc

	task automatic wait_st(input logic [15:0] e);
		logic [15:0] v;
		logic [1:0]  r;
		for (int n = 0; n < 200; n++) begin
			rd(OFF_STATUS, v, r);
			if (v === e)
				break;
		end
		`CHK("status", e, v)
		if (v !== e)
			end_sim();
	endtask : wait_st

	task automatic cfg(input logic [15:0] st, c1, rp);
		rep <= rp;
		load <= 1'b1;
		w(OFF_CTRL1, c1);
		load <= 1'b0;
		w(OFF_STATUS, st);
		nedge = 0;
	endtask : cfg

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] v;
		logic [1:0]  r;
		for (int i = 0; i < 4; i++)
			rc(8'(i * 4), 16'h0000);
		w(OFF_CTRL1, 16'hFFFF);
		rc(OFF_CTRL1, 16'h1FFF);
		w(OFF_CTRL1, 16'h0000);
		w(OFF_CTRL2, 16'hFFFF);
		rc(OFF_CTRL2, 16'hE002);
		w(OFF_CTRL2, 16'h0000);
		w(OFF_STATUS, 16'hFFFF);
		rc(OFF_STATUS, 16'hA000);
		w(OFF_STATUS, 16'h0000);
		wr(8'h10, 16'h1234, r);
		`CHK("unmapped write", RESP_SLVERR, r)
		rd(8'h10, v, r);
		`CHK("unmapped read", RESP_SLVERR, r)
	endtask : t_regs

	task automatic t_byte;
		cfg(16'hA000, 16'h0123, 16'h3C00);
		idle_mode <= 1'b1;
		w(OFF_DATA, 16'h00A5);
		repeat (20) @(posedge clk);
		rc(OFF_STATUS, 16'hA002);
		idle_mode <= 1'b0;
		wait_st(16'hA001);
		`CHK("byte edges", 8, nedge)
		`CHK("byte span", 7 * 8, last - first)
		`CHK("byte out", 8'hA5, got[7:0])
		rc(OFF_DATA, 16'h003C);
		rc(OFF_STATUS, 16'hA000);
	endtask : t_byte

	task automatic t_ovf;
		cfg(16'h8000, 16'h0123, 16'h5A00);
		w(OFF_DATA, 16'h0011);
		wait_st(16'h8001);
		cfg(16'h8000, 16'h0123, 16'h6600);
		w(OFF_DATA, 16'h0022);
		wait_st(16'h8041);
		rc(OFF_DATA, 16'h005A);
		w(OFF_STATUS, 16'h8000);
		rc(OFF_STATUS, 16'h8000);
	endtask : t_ovf

	task automatic t_word;
		// sample at the end of each output slot, set along with master
		cfg(16'h8000, 16'h073D, 16'hC3A5);
		w(OFF_DATA, 16'h9E17);
		wait_st(16'h8001);
		`CHK("word edges", 16, nedge)
		`CHK("word span", 15 * 16, last - first)
		`CHK("word out", 16'h9E17, got)
		rc(OFF_DATA, 16'hC3A5);
	endtask : t_word

	// bench plays master on the clock and select pins, slow enough to sync
	task automatic t_slave;
		logic [7:0] q;
		cfg(16'h8000, 16'h0180, 16'hFFFF);
		w(OFF_DATA, 16'h00C3);
		sel_in <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (8) @(posedge clk);
			sck_in <= 1'b1;
			q = {q[6:0], so};
			repeat (8) @(posedge clk);
			sck_in <= 1'b0;
		end
		sel_in <= 1'b1;
		wait_st(16'h8001);
		`CHK("slave out", 8'hC3, q)
		rc(OFF_DATA, 16'h00FF);
	endtask : t_slave

	task automatic t_pins;
		cfg(16'h8000, 16'h0163, 16'h0000);
		repeat (4) @(posedge clk);
		`CHK("clock idle", 1'b1, sck_o)
		`CHK("clock drive", 1'b0, sck_oe_n)
		`CHK("data drive", 1'b0, so_oe_n)
		w(OFF_CTRL1, 16'h1963);
		repeat (4) @(posedge clk);
		`CHK("pins freed", 2'b11, {sck_oe_n, so_oe_n})
		w(OFF_CTRL1, 16'h0123);
		w(OFF_STATUS, 16'h0000);
		repeat (4) @(posedge clk);
		`CHK("port off", 2'b11, {sck_oe_n, so_oe_n})
		// framed master: edge bit and select enable stay clear here
		w(OFF_CTRL2, 16'h8000);
		cfg(16'h8000, 16'h0023, 16'h0000);
		repeat (80) @(posedge clk);
		`CHK("free clock", 1'b1, nedge >= 9)
		`CHK("sync drive", 1'b0, sel_oe_n)
		`CHK("sync low idle", 1'b1, sel_o)
		w(OFF_CTRL2, 16'hA000);
		repeat (4) @(posedge clk);
		`CHK("sync high idle", 1'b0, sel_o)
		w(OFF_CTRL2, 16'hC000);
		repeat (4) @(posedge clk);
		`CHK("sync input", 1'b1, sel_oe_n)
	endtask : t_pins

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		$display("t_regs done");
		t_byte();
		$display("t_byte done");
		t_ovf();
		$display("t_ovf done");
		t_word();
		$display("t_word done");
		t_slave();
		$display("t_slave done");
		t_pins();
		$display("t_pins done");
		end_sim();
	end
endmodule : spi_port_test

`default_nettype wire
